// [rtl/ptb_map.vh]
// Register offsets, field positions and reset values of the PWM time base
`ifndef PTB_MAP_VH
`define PTB_MAP_VH
// Word byte addresses
`define PTB_CTRL_ADDR 8'h00
`define PTB_PERIOD_ADDR 8'h04
`define PTB_PHASE_ADDR 8'h08
`define PTB_COUNT_ADDR 8'h0c
`define PTB_CMP_CTRL_ADDR 8'h10
`define PTB_COMPARE_A_ADDR 8'h14
`define PTB_COMPARE_B_ADDR 8'h18
`define PTB_GLOBAL_ADDR 8'h1c
// Control fields
`define PTB_CTRL_MODE_LSB 0
`define PTB_CTRL_PHS_EN 2
`define PTB_CTRL_PRD_LOAD 3
`define PTB_CTRL_SW_SYNC 4
`define PTB_CTRL_SYNC_DIR 5
`define PTB_CTRL_SYNCO_SEL 6
`define PTB_CTRL_PRESC_LSB 8
`define PTB_CTRL_WIDTH 11
`define PTB_CTRL_RESET 11'h003
// Count modes
`define PTB_MODE_UP 2'h0
`define PTB_MODE_DOWN 2'h1
`define PTB_MODE_UPDOWN 2'h2
`define PTB_MODE_FROZEN 2'h3
// Compare control fields
`define PTB_CC_A_LOAD_LSB 0
`define PTB_CC_B_LOAD_LSB 2
`define PTB_CC_A_IMM 4
`define PTB_CC_B_IMM 6
`define PTB_CC_WIDTH 7
`define PTB_CC_RESET 7'h00
// Load points
`define PTB_LOAD_ZERO 2'h0
`define PTB_LOAD_PERIOD 2'h1
`define PTB_LOAD_BOTH 2'h2
`endif

// [rtl/ptb_time_base.v]
// PWM time-base counter with shadowed period and compare events
// What this block and its software do
// R1: Up-down mode counts zero to period, back
// R2: Up mode wraps to zero after period
// R3: Down mode reloads period after zero
// R4: Frozen mode holds the counter
// R5: Period load select 0 maps to shadow
// R6: Shadow period loads at counter zero
// R7: Period shadowing enabled after reset
// R8: Period load select 1 maps to active
// R9: Only active registers drive hardware
// R10: Sync loads phase on next tick
// R11: Software sync bit ORs with sync input
// R12: Up-down direction after sync from bit
// R13: Phase disabled ignores sync, still passes out
// R14: Global run bit gates all ticks
// R15: Software stops ticks before configuring
// R16: Software sets identical prescalers everywhere
// R17: Each tick compare against A and B
// R18: Tick comes from prescaled system clock
// R19: Compare values buffered in shadows
// R20: Compare events once or twice per cycle
// R21: Compare shadows enabled after reset
// R22: Load point selects zero, period, both
// R23: Immediate bit maps compare to active
// R24: Sixteen bit values, direction flag
// R25: Zero and period event pulses
`timescale 1ns/1ps
`include "ptb_map.vh"
module ptb_time_base (
   input wire ref_clk,
   input wire arst_n,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire sync_in,
   input wire global_tick_run,
   output reg sync_out,
   output reg [15:0] counter_value,
   output reg count_direction_flag,
   output reg count_tick,
   output reg ctr_zero,
   output reg ctr_period,
   output reg ctr_compare_a,
   output reg ctr_compare_b
);
   // Load point decode, shared by both compares
   function load_now;
      input [1:0] point;
      input zero_ev;
      input prd_ev;
      begin
         case (point)
            `PTB_LOAD_ZERO: load_now = zero_ev;
            `PTB_LOAD_PERIOD: load_now = prd_ev;
            `PTB_LOAD_BOTH: load_now = zero_ev | prd_ev;
            default: load_now = 1'b0;
         endcase
      end
   endfunction

   reg [10:0] ctrl_reg;
   reg [6:0] cc_ctrl_reg;
   reg [15:0] prd_act_reg;
   reg [15:0] prd_shd_reg;
   reg [15:0] phase_reg;
   // Active and shadow compare words, driven from the generate loop
   wire [15:0] cmp_act [0:1];
   wire [15:0] cmp_shd [0:1];
   reg run_s1_reg;
   reg run_s2_reg;
   reg run_d_reg;
   reg sync_s1_reg;
   reg sync_s2_reg;
   reg sync_d_reg;
   reg sync_pend_reg;
   reg sw_sync_reg;

   wire [1:0] mode = ctrl_reg[`PTB_CTRL_MODE_LSB +: 2];
   wire phs_en = ctrl_reg[`PTB_CTRL_PHS_EN];
   wire prd_imm = ctrl_reg[`PTB_CTRL_PRD_LOAD];
   wire sync_dir = ctrl_reg[`PTB_CTRL_SYNC_DIR];
   wire [2:0] presc_sel = ctrl_reg[`PTB_CTRL_PRESC_LSB +: 3];
   wire [1:0] load_pt [0:1];
   wire cmp_imm [0:1];
   assign load_pt[0] = cc_ctrl_reg[`PTB_CC_A_LOAD_LSB +: 2];
   assign load_pt[1] = cc_ctrl_reg[`PTB_CC_B_LOAD_LSB +: 2];
   assign cmp_imm[0] = cc_ctrl_reg[`PTB_CC_A_IMM];
   assign cmp_imm[1] = cc_ctrl_reg[`PTB_CC_B_IMM];

   wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   // Writes land at the edge where the master sees ack
   wire wr_req = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;
   wire wr_lo = wr_req & wb_sel_i[0];
   wire wr_hi = wr_req & wb_sel_i[1];

   // Byte-lane merge of write data onto an old 16-bit value
   function [15:0] merge16;
      input [15:0] old;
      input [31:0] dat;
      input lo;
      input hi;
      begin
         merge16 = {hi ? dat[15:8] : old[15:8], lo ? dat[7:0] : old[7:0]};
      end
   endfunction

   // Synchronisers for the run gate and sync pin
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         run_s1_reg <= 1'b0;
         run_s2_reg <= 1'b0;
         run_d_reg <= 1'b0;
         sync_s1_reg <= 1'b0;
         sync_s2_reg <= 1'b0;
         sync_d_reg <= 1'b0;
      end else begin
         run_s1_reg <= global_tick_run;
         run_s2_reg <= run_s1_reg;
         run_d_reg <= run_s2_reg;
         sync_s1_reg <= sync_in;
         sync_s2_reg <= sync_s1_reg;
         sync_d_reg <= sync_s2_reg;
      end
   end

   wire sync_edge = sync_s2_reg & ~sync_d_reg;
   // R11: software pulse ORed with pin
   wire sync_event = sync_edge | sw_sync_reg;

   // R18: prescaler divides the clock by 2^sel
   wire [7:0] presc_max = (8'h01 << presc_sel) - 8'h01;
   reg [7:0] presc_cnt_reg;
   // R14: tick runs only while run bit is set, aligned at start
   wire tick_w = run_s2_reg & run_d_reg & (presc_cnt_reg >= presc_max);
   // Prescaler count, held at zero until the run gate settles
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         presc_cnt_reg <= 8'h00;
      end else if (!run_d_reg || tick_w) begin
         presc_cnt_reg <= 8'h00;
      end else begin
         presc_cnt_reg <= presc_cnt_reg + 8'h01;
      end
   end

   // Counter next value per mode
   wire at_zero = (counter_value == 16'h0000);
   wire at_prd = (counter_value == prd_act_reg);
   reg [15:0] cnt_next;
   reg dir_next;
   always @* begin
      cnt_next = counter_value;
      dir_next = count_direction_flag;
      if (sync_pend_reg && phs_en) begin
         // R10: phase loaded on the tick after sync
         cnt_next = phase_reg;
         // R12: direction taken from the sync bit
         if (mode == `PTB_MODE_UPDOWN)
            dir_next = sync_dir;
      end else begin
         case (mode)
            // R2: wrap to zero at period
            `PTB_MODE_UP: begin
               dir_next = 1'b1;
               cnt_next = (counter_value >= prd_act_reg) ? 16'h0000 : counter_value + 16'h0001;
            end
            // R3: reload period at zero
            `PTB_MODE_DOWN: begin
               dir_next = 1'b0;
               cnt_next = at_zero ? prd_act_reg : counter_value - 16'h0001;
            end
            // R1: triangle, turning at period and zero
            `PTB_MODE_UPDOWN: begin
               if (count_direction_flag) begin
                  if (counter_value >= prd_act_reg) begin
                     dir_next = 1'b0;
                     cnt_next = at_zero ? 16'h0000 : counter_value - 16'h0001;
                  end else begin
                     cnt_next = counter_value + 16'h0001;
                  end
               end else begin
                  if (at_zero) begin
                     dir_next = 1'b1;
                     cnt_next = (prd_act_reg == 16'h0000) ? 16'h0000 : 16'h0001;
                  end else begin
                     cnt_next = counter_value - 16'h0001;
                  end
               end
            end
            // R4: frozen holds the value
            default: begin
               cnt_next = counter_value;
            end
         endcase
      end
   end

   // Counter, direction and event outputs
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         counter_value <= 16'h0000;
         count_direction_flag <= 1'b1;
         count_tick <= 1'b0;
         ctr_zero <= 1'b0;
         ctr_period <= 1'b0;
         ctr_compare_a <= 1'b0;
         ctr_compare_b <= 1'b0;
         sync_out <= 1'b0;
         sync_pend_reg <= 1'b0;
      end else begin
         count_tick <= tick_w;
         // R13: sync passes downstream regardless of phase enable
         sync_out <= ctrl_reg[`PTB_CTRL_SYNCO_SEL] ? (tick_w & at_zero) : sync_event;
         if (tick_w) begin
            sync_pend_reg <= sync_event;
         end else if (sync_event) begin
            sync_pend_reg <= 1'b1;
         end
         // Software write to the counter wins over a step
         if (wr_req && wb_adr_i == `PTB_COUNT_ADDR) begin
            counter_value <= merge16(counter_value, wb_dat_i, wr_lo, wr_hi);
         end else if (tick_w) begin
            counter_value <= cnt_next;
            // R24: direction flag high while counting up
            count_direction_flag <= dir_next;
         end
         // R25: one-tick zero and period pulses
         ctr_zero <= tick_w & at_zero;
         ctr_period <= tick_w & at_prd;
         // R17: equality with active compares each tick
         // R20: one event per visit of the compare value
         ctr_compare_a <= tick_w & (counter_value == cmp_act[0]);
         ctr_compare_b <= tick_w & (counter_value == cmp_act[1]);
      end
   end

   // Register writes and shadow transfers
   wire ld_zero = tick_w & at_zero;
   wire ld_prd = tick_w & at_prd;
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         // R7: period shadow enabled after reset
         ctrl_reg <= `PTB_CTRL_RESET;
         // R21: both compares shadowed after reset
         cc_ctrl_reg <= `PTB_CC_RESET;
         prd_act_reg <= 16'h0000;
         prd_shd_reg <= 16'h0000;
         phase_reg <= 16'h0000;
         sw_sync_reg <= 1'b0;
      end else begin
         sw_sync_reg <= 1'b0;
         if (wr_req && wb_adr_i == `PTB_CTRL_ADDR) begin
            if (wb_sel_i[0]) begin
               ctrl_reg[3:0] <= wb_dat_i[3:0];
               ctrl_reg[7:5] <= wb_dat_i[7:5];
               // R11: writing one fires a single sync pulse
               sw_sync_reg <= wb_dat_i[`PTB_CTRL_SW_SYNC];
            end
            if (wb_sel_i[1])
               ctrl_reg[10:8] <= wb_dat_i[10:8];
         end
         if (wr_req && wb_adr_i == `PTB_CMP_CTRL_ADDR && wb_sel_i[0])
            cc_ctrl_reg <= wb_dat_i[6:0];
         if (wr_req && wb_adr_i == `PTB_PHASE_ADDR)
            phase_reg <= merge16(phase_reg, wb_dat_i, wr_lo, wr_hi);
         // R8: immediate mode writes the active period
         if (wr_req && wb_adr_i == `PTB_PERIOD_ADDR && prd_imm) begin
            prd_act_reg <= merge16(prd_act_reg, wb_dat_i, wr_lo, wr_hi);
         end else if (!prd_imm && ld_zero) begin
            // R6: shadow moves to active at zero
            prd_act_reg <= prd_shd_reg;
         end
         // R5: shadow mode writes land in the shadow
         if (wr_req && wb_adr_i == `PTB_PERIOD_ADDR && !prd_imm)
            prd_shd_reg <= merge16(prd_shd_reg, wb_dat_i, wr_lo, wr_hi);
      end
   end

   // Compare A and B shadow pairs
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_cmp
         wire [7:0] my_addr = (gi == 0) ? `PTB_COMPARE_A_ADDR : `PTB_COMPARE_B_ADDR;
         wire hit = wr_req && (wb_adr_i == my_addr);
         // Each pair lives in its own slice, one driver each
         reg [15:0] act_reg;
         reg [15:0] shd_reg;
         assign cmp_act[gi] = act_reg;
         assign cmp_shd[gi] = shd_reg;
         always @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
               act_reg <= 16'h0000;
               shd_reg <= 16'h0000;
            end else begin
               // R23: immediate mode writes go to active
               if (hit && cmp_imm[gi]) begin
                  act_reg <= merge16(act_reg, wb_dat_i, wr_lo, wr_hi);
               end else if (!cmp_imm[gi] &&
                            load_now(load_pt[gi], ld_zero, ld_prd)) begin
                  // R22: transfer at the chosen load point
                  act_reg <= shd_reg;
               end
               // R19: shadow buffers writes in shadow mode
               if (hit && !cmp_imm[gi])
                  shd_reg <= merge16(shd_reg, wb_dat_i, wr_lo, wr_hi);
            end
         end
      end
   endgenerate

   // Read mux, shadow or active per mode
   reg [31:0] rd_data;
   always @* begin
      case (wb_adr_i)
         `PTB_CTRL_ADDR: rd_data = {21'h000000, ctrl_reg};
         // R9: shadow read only through its shared address
         `PTB_PERIOD_ADDR: rd_data = {16'h0000, prd_imm ? prd_act_reg : prd_shd_reg};
         `PTB_PHASE_ADDR: rd_data = {16'h0000, phase_reg};
         `PTB_COUNT_ADDR: rd_data = {15'h0000, count_direction_flag, counter_value};
         `PTB_CMP_CTRL_ADDR: rd_data = {25'h0000000, cc_ctrl_reg};
         `PTB_COMPARE_A_ADDR: rd_data = {16'h0000, cmp_imm[0] ? cmp_act[0] : cmp_shd[0]};
         `PTB_COMPARE_B_ADDR: rd_data = {16'h0000, cmp_imm[1] ? cmp_act[1] : cmp_shd[1]};
         `PTB_GLOBAL_ADDR: rd_data = {31'h00000000, run_s2_reg};
         default: rd_data = 32'h00000000;
      endcase
   end

   // Wishbone answer one cycle after request
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= bus_req ? rd_data : 32'h00000000;
      end
   end
endmodule

// [tb/ptb_time_base_asserts.sv]
// Port checker for the PWM time base
`timescale 1ns/1ps
module ptb_time_base_asserts (
   input wire ref_clk,
   input wire arst_n,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_ack_o,
   input wire [31:0] wb_dat_o,
   input wire global_tick_run,
   input wire [15:0] counter_value,
   input wire count_tick,
   input wire ctr_zero,
   input wire ctr_period,
   input wire ctr_compare_a,
   input wire ctr_compare_b
);
   default clocking cb_clk @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   // Bus answers one cycle after a request
   a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack did not follow request");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held too long");
   a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not zero when idle");
   a_zero_event: assert property (count_tick |-> ctr_zero == ($past(counter_value) == 16'h0))
      else $error("zero event mismatch");
   a_compare_a_on_tick: assert property (ctr_compare_a |-> count_tick)
      else $error("compare A event off tick");
   a_compare_b_on_tick: assert property (ctr_compare_b |-> count_tick)
      else $error("compare B event off tick");
   a_count_moves: assert property ($changed(counter_value) |-> count_tick || $past(wb_ack_o))
      else $error("counter moved without tick");
   a_prd_on_tick: assert property (ctr_period |-> count_tick)
      else $error("period event off tick");
   a_run_gate: assert property ((!global_tick_run) [*6] |-> !count_tick)
      else $error("tick while gated");
endmodule
bind ptb_time_base ptb_time_base_asserts chk_i (
   .ref_clk(ref_clk),
   .arst_n(arst_n),
   .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o),
   .wb_dat_o(wb_dat_o),
   .global_tick_run(global_tick_run),
   .counter_value(counter_value),
   .count_tick(count_tick),
   .ctr_zero(ctr_zero),
   .ctr_period(ctr_period),
   .ctr_compare_a(ctr_compare_a),
   .ctr_compare_b(ctr_compare_b)
);

// [tb/ptb_sync_peer.sv]
// Neighbour module driving the sync chain pin
`timescale 1ns/1ps
module ptb_sync_peer (
   input wire ref_clk,
   input wire fire,
   output reg sync_in
);
   reg [2:0] len_reg = 3'h0;
   initial sync_in = 1'b0;
   // Pulse wide enough for the input synchroniser
   always @(posedge ref_clk) begin
      if (fire)
         len_reg <= 3'h4;
      else if (len_reg != 3'h0)
         len_reg <= len_reg - 3'h1;
      sync_in <= fire || len_reg > 3'h1;
   end
endmodule

// [tb/ptb_time_base_test.sv]
// Self-checking bench for the PWM time base
`timescale 1ns/1ps
`include "ptb_map.vh"
module ptb_time_base_test;
   reg ref_clk = 1'b0;
   reg arst_n = 1'b0;
   reg wb_cyc_i = 1'b0;
   reg wb_stb_i = 1'b0;
   reg wb_we_i = 1'b0;
   reg [7:0] wb_adr_i = 8'h00;
   reg [3:0] wb_sel_i = 4'h3;
   reg [31:0] wb_dat_i = 32'h0;
   reg global_tick_run = 1'b0;
   reg fire = 1'b0;
   wire [31:0] wb_dat_o;
   wire wb_ack_o, sync_in, sync_out, count_direction_flag, count_tick;
   wire ctr_zero, ctr_period, ctr_compare_a, ctr_compare_b;
   wire [15:0] counter_value;
   integer fail_count = 0;
   integer checks_done = 0;
   integer t, c, ca, cb, p, i;
   reg [31:0] q;
   // 20 MHz system clock
   always #25 ref_clk = ~ref_clk;
   ptb_time_base dut (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o),
      .sync_in(sync_in),
      .global_tick_run(global_tick_run),
      .sync_out(sync_out),
      .counter_value(counter_value),
      .count_direction_flag(count_direction_flag),
      .count_tick(count_tick),
      .ctr_zero(ctr_zero),
      .ctr_period(ctr_period),
      .ctr_compare_a(ctr_compare_a),
      .ctr_compare_b(ctr_compare_b)
   );
   ptb_sync_peer peer (.ref_clk(ref_clk), .fire(fire), .sync_in(sync_in));
   task tally_and_finish;
      begin
         $display("checks %0d mismatches %0d", checks_done, fail_count);
         if (fail_count == 0 && checks_done > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   task chk(input [95:0] nm, input [31:0] s, input [31:0] e);
      begin
         checks_done = checks_done + 1;
         if (s !== e) begin
            fail_count = fail_count + 1;
            $display("FAIL %0s exp %h seen %h", nm, e, s);
         end
      end
   endtask
   task guard(input integer n, input integer lim);
      begin
         if (n > lim) begin
            fail_count = fail_count + 1;
            tally_and_finish;
         end
      end
   endtask
   // Classic single cycle, held until ack
   task wb(input w, input [7:0] a, input [31:0] d);
      integer n;
      begin
         wb_cyc_i <= 1'b1;
         wb_stb_i <= 1'b1;
         wb_we_i <= w;
         wb_adr_i <= a;
         wb_dat_i <= d;
         n = 0;
         @(posedge ref_clk);
         while (wb_ack_o !== 1'b1) begin
            n = n + 1;
            guard(n, 9);
            @(posedge ref_clk);
         end
         q = wb_dat_o;
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
         @(posedge ref_clk);
      end
   endtask
   task rc(input [95:0] nm, input [7:0] a, input [31:0] e);
      begin
         wb(1'b0, a, 32'h0);
         chk(nm, q, e);
      end
   endtask
   // Wait for tick, zero event or sync out
   task wt(input integer s);
      integer n;
      begin
         n = 0;
         @(posedge ref_clk);
         while ((s == 0 ? count_tick : s == 1 ? ctr_zero : sync_out) !== 1'b1) begin
            n = n + 1;
            guard(n, 999);
            @(posedge ref_clk);
         end
      end
   endtask
   // Count clocks, ticks and compare events between zero events
   task span;
      begin
         wt(1);
         {t, c, ca, cb} = 128'h0;
         p = 0;
         do begin
            @(posedge ref_clk);
            c = c + 1;
            t = t + count_tick;
            ca = ca + ctr_compare_a;
            cb = cb + ctr_compare_b;
            p = p + ctr_period;
            guard(c, 999);
         end while (ctr_zero !== 1'b1);
      end
   endtask
   task t_reset;
      begin
         rc("ctrl", `PTB_CTRL_ADDR, 32'h3);
         rc("cmp ctrl", `PTB_CMP_CTRL_ADDR, 32'h0);
         rc("count", `PTB_COUNT_ADDR, 32'h10000);
         rc("unmapped", 8'h20, 32'h0);
      end
   endtask
   // Configure while ticks are stopped, then start
   task t_gate;
      begin
         wb(1'b1, `PTB_CTRL_ADDR, 32'h108);
         wb(1'b1, `PTB_PERIOD_ADDR, 32'h4);
         wb(1'b1, `PTB_CMP_CTRL_ADDR, 32'h10);
         wb(1'b1, `PTB_COMPARE_A_ADDR, 32'h2);
         wb(1'b1, `PTB_COMPARE_B_ADDR, 32'h3);
         t = 0;
         repeat (40) begin
            @(posedge ref_clk);
            t = t + count_tick;
         end
         chk("gated", t, 0);
         global_tick_run <= 1'b1;
         wt(0);
      end
   endtask
   task t_modes;
      begin
         for (i = 0; i < 3; i = i + 1) begin
            wb(1'b1, `PTB_CTRL_ADDR, 32'h108 | i);
            repeat (2) span;
            chk("ticks", t, i == 2 ? 8 : 5);
            chk("clocks", c, i == 2 ? 16 : 10);
            chk("compare_a", ca, i == 2 ? 2 : 1);
            chk("compare_b", cb, i == 2 ? 2 : 1);
            chk("prd ev", p, 1);
         end
      end
   endtask
   task t_frozen;
      reg [31:0] was;
      begin
         wb(1'b1, `PTB_CTRL_ADDR, 32'h10b);
         wb(1'b0, `PTB_COUNT_ADDR, 32'h0);
         was = q;
         repeat (20) @(posedge ref_clk);
         rc("frozen", `PTB_COUNT_ADDR, was);
         wb_sel_i <= 4'h1;
         wb(1'b1, `PTB_COUNT_ADDR, 32'hff02);
         wb_sel_i <= 4'h3;
         rc("count wr", `PTB_COUNT_ADDR, {was[31:8], 8'h02});
      end
   endtask
   task t_shadow;
      begin
         wb(1'b1, `PTB_CTRL_ADDR, 32'h100);
         wb(1'b1, `PTB_PERIOD_ADDR, 32'h6);
         rc("prd shadow", `PTB_PERIOD_ADDR, 32'h6);
         repeat (2) span;
         chk("prd load", t, 7);
         wb(1'b1, `PTB_CTRL_ADDR, 32'h108);
         wb(1'b1, `PTB_PERIOD_ADDR, 32'h2);
         rc("prd active", `PTB_PERIOD_ADDR, 32'h2);
         repeat (2) span;
         chk("prd imm", t, 3);
      end
   endtask
   task t_cmp;
      begin
         wb(1'b1, `PTB_COMPARE_B_ADDR, 32'h1);
         repeat (2) span;
         chk("compare_b load", cb, 1);
         wb(1'b1, `PTB_CMP_CTRL_ADDR, 32'h1c);
         wb(1'b1, `PTB_COMPARE_B_ADDR, 32'h7);
         repeat (2) span;
         chk("compare_b none", cb, 1);
         wb(1'b1, `PTB_CMP_CTRL_ADDR, 32'h14);
         repeat (2) span;
         chk("compare_b prd", cb, 0);
         wb(1'b1, `PTB_COMPARE_A_ADDR, 32'h7);
         span;
         chk("compare_a imm", ca, 0);
      end
   endtask
   // Pin or software sync well away from a tick
   task sync_try(input sw, input d);
      begin
         wt(0);
         repeat (5) @(posedge ref_clk);
         if (sw)
            wb(1'b1, `PTB_CTRL_ADDR, 32'h71e);
         else begin
            fire <= 1'b1;
            @(posedge ref_clk);
            fire <= 1'b0;
         end
         wt(0);
         chk("phase", {16'h0, counter_value}, 32'h3);
         chk("sync dir", {31'h0, count_direction_flag}, {31'h0, d});
      end
   endtask
   task t_sync;
      begin
         wb(1'b1, `PTB_PERIOD_ADDR, 32'h64);
         wb(1'b1, `PTB_PHASE_ADDR, 32'h3);
         wb(1'b1, `PTB_CTRL_ADDR, 32'h72e);
         sync_try(1'b0, 1'b1);
         sync_try(1'b1, 1'b0);
      end
   endtask
   task t_pass;
      begin
         wb(1'b1, `PTB_PHASE_ADDR, 32'h32);
         wb(1'b1, `PTB_CTRL_ADDR, 32'h70a);
         wt(0);
         fire <= 1'b1;
         @(posedge ref_clk);
         fire <= 1'b0;
         wt(2);
         wt(0);
         chk("no phase", {31'h0, counter_value == 16'h32}, 32'h0);
      end
   endtask
   // Reset, then the scenarios in turn
   initial begin
      repeat (10) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(posedge ref_clk);
      t_reset;
      t_gate;
      t_modes;
      t_frozen;
      t_shadow;
      t_cmp;
      t_sync;
      t_pass;
      tally_and_finish;
   end
endmodule
